// file: bmd_pkg.sv
// Package for the board memory decode and control block.
// Assumes a 24-bit processor address bus and a 100 MHz system clock.
package bmd_pkg;

  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned REFRESH_PERIOD_US   = 15;
  localparam int unsigned REFRESH_CYCLES      = (REFRESH_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CNT_W       = 11;

  localparam logic [23:0] ROM_BASE            = 24'hF80000;
  localparam logic [23:0] ROM_TOP             = 24'hFFFFFF;
  localparam logic [23:0] ROM_ALIAS_BASE      = 24'h0E0000;
  localparam logic [23:0] ROM_ALIAS_TOP       = 24'h0FFFFF;
  localparam logic [23:0] ROM_ALIAS_TARGET    = 24'hFE0000;
  localparam logic [23:0] RAM_BASE            = 24'h000000;
  localparam logic [23:0] RAM_LOW_TOP         = 24'h09FFFF;
  localparam logic [23:0] VIDEO_BASE          = 24'h0A0000;
  localparam logic [23:0] VIDEO_TOP           = 24'h0BFFFF;
  localparam logic [23:0] ADAPTER_BASE        = 24'h0C0000;
  localparam logic [23:0] ADAPTER_TOP         = 24'h0DFFFF;
  localparam logic [23:0] RAM_HIGH_BASE       = 24'h100000;
  localparam logic [23:0] RAM_HIGH_TOP        = 24'h15FFFF;
  localparam logic [23:0] CHANNEL_BASE        = 24'h160000;
  localparam logic [23:0] CHANNEL_TOP         = 24'hF7FFFF;
  localparam logic [23:0] CARD_BANK_BASE      = 24'h080000;

  localparam int unsigned BANK_SHIFT          = 17;
  localparam int unsigned NUM_BANKS           = 5;

  localparam logic [15:0] BANK_ENABLE_PORT    = 16'h0104;
  localparam logic [7:0]  BANK_ENABLE_RESET   = 8'h1F;
  localparam logic [7:0]  BANK_ENABLE_MASK    = 8'h1F;

  typedef enum logic [2:0] {
    BMD_TGT_NONE,
    BMD_TGT_ROM,
    BMD_TGT_RAM,
    BMD_TGT_VIDEO,
    BMD_TGT_ADAPTER,
    BMD_TGT_CHANNEL
  } bmd_target_t;

endpackage

// file: bmd_board_memory.sv
// Board memory decoder with RAM wait state, refresh and bank enable port.
// Assumes one processor cycle at a time, held until memReady, on the same clock.
`timescale 1ns/1ps
module bmd_board_memory
  import bmd_pkg::*;
(
  input  wire logic              clk,           // System clock.
  input  wire logic              arst_n,        // Asynchronous reset, active low.
  input  wire logic              memReq,        // Memory cycle request, held until memReady.
  input  wire logic              memWrite,      // Memory cycle is a write.
  input  wire logic [23:0]       memAddr,       // Processor byte address.
  input  wire logic              ioWrite,       // I/O write strobe, one cycle.
  input  wire logic              ioRead,        // I/O read strobe, one cycle.
  input  wire logic [15:0]       ioAddr,        // I/O port address.
  input  wire logic [7:0]        ioWdata,       // I/O write data.
  input  wire logic              setupMode,     // System board is in setup.
  input  wire logic              ramOptionIn,   // RAM option installed (card present).
  input  wire logic [15:0]       romData,       // ROM word from the paired byte modules.
  output logic                   memReady,      // Cycle complete, one-cycle pulse.
  output logic [15:0]            memRdata,      // Read word for ROM cycles.
  output bmd_pkg::bmd_target_t   memTarget,     // Decoded target of the last cycle.
  output logic                   ramSel,        // Soldered board RAM strobe.
  output logic                   cardBankSel,   // Plug-in card second bank strobe.
  output logic                   romSel,        // ROM strobe.
  output logic [17:0]            romAddr,       // ROM word address inside 512KB.
  output logic                   channelSel,    // Cycle passed to video, adapter or channel.
  output logic                   refreshReq,    // Refresh cycle active, one-cycle pulse.
  output logic [7:0]             ioRdata,       // I/O read data.
  output logic                   ioRvalid       // I/O read data valid, one-cycle pulse.
);
  import bmd_pkg::*;

  typedef enum logic [1:0] {BMD_IDLE, BMD_WAIT, BMD_DONE, BMD_REFRESH} bmd_state_t;

  bmd_state_t             state_reg;
  logic [7:0]             bankEnable_reg;
  logic [REFRESH_CNT_W-1:0] refreshCnt_reg;
  logic                   refreshPend_reg;
  logic [2:0]             optSync_reg;
  logic                   ramOption_reg;
  bmd_target_t            target;
  logic                   toCard;
  logic [NUM_BANKS-1:0]   bankHit;

  // Bank decode within the low 640KB.
  function automatic logic [NUM_BANKS-1:0] bmd_bank_hit(input logic [23:0] a);
    logic [NUM_BANKS-1:0] h;
    h = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (a[23:BANK_SHIFT] == 7'(i)) begin
        h[i] = 1'b1;
      end
    end
    return h;
  endfunction

  assign bankHit = bmd_bank_hit(memAddr) & bankEnable_reg[NUM_BANKS-1:0];

  // Decode order matters: the ROM windows and the two reserved windows are
  // tested before the RAM range, so a disabled bank or a missing option can
  // only ever fall through to the channel, never onto another board device.
  // The RAM option also hands the last low bank (from CARD_BANK_BASE) to the
  // card, so with it the soldered banks answer only below 512KB.
  always_comb begin
    target = BMD_TGT_CHANNEL;
    toCard = 1'b0;
    if (memAddr >= ROM_BASE) begin
      target = BMD_TGT_ROM;
    end else if (memAddr >= ROM_ALIAS_BASE && memAddr <= ROM_ALIAS_TOP) begin
      target = BMD_TGT_ROM;
    end else if (memAddr >= ADAPTER_BASE && memAddr <= ADAPTER_TOP) begin
      target = BMD_TGT_ADAPTER;
    end else if (memAddr >= VIDEO_BASE && memAddr <= VIDEO_TOP) begin
      target = BMD_TGT_VIDEO;
    end else if (memAddr <= RAM_LOW_TOP) begin
      // A disabled bank leaves the cycle for expansion memory.
      target = (|bankHit) ? BMD_TGT_RAM : BMD_TGT_CHANNEL;
      toCard = ramOption_reg && memAddr >= CARD_BANK_BASE;
    end else if (ramOption_reg && memAddr >= RAM_HIGH_BASE && memAddr <= RAM_HIGH_TOP) begin
      target = BMD_TGT_RAM;
      toCard = 1'b1;
    end
  end

  // The option strap comes from a connector pin, so it is synchronised.
  // A change is taken only once two stages agree, so a bouncing pin cannot
  // flip the RAM map in the middle of a cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      optSync_reg   <= 3'h0;
      ramOption_reg <= 1'b0;
    end else begin
      optSync_reg <= {optSync_reg[1:0], ramOptionIn};
      if (optSync_reg[1] == optSync_reg[2]) begin
        ramOption_reg <= optSync_reg[2];
      end
    end
  end

  // Writes outside setup are dropped silently.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bankEnable_reg <= BANK_ENABLE_RESET;
    end else if (ioWrite && ioAddr == BANK_ENABLE_PORT && setupMode) begin
      bankEnable_reg <= ioWdata & BANK_ENABLE_MASK;
    end
  end

  // Reads of any other port return zero so a stray read cannot show stale
  // bank bits; the reserved bits always read back as zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ioRdata  <= 8'h00;
      ioRvalid <= 1'b0;
    end else begin
      ioRvalid <= ioRead;
      ioRdata  <= (ioRead && ioAddr == BANK_ENABLE_PORT) ? bankEnable_reg : 8'h00;
    end
  end

  // Refresh timer: the request stays pending until the RAM is idle.
  // The timer runs free and is never held by traffic, so refreshes keep
  // their average rate even when one of them has to wait for a RAM cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refreshCnt_reg  <= '0;
      refreshPend_reg <= 1'b0;
    end else begin
      if (refreshCnt_reg == REFRESH_CNT_W'(REFRESH_CYCLES - 1)) begin
        refreshCnt_reg  <= '0;
        refreshPend_reg <= 1'b1;
      end else begin
        refreshCnt_reg <= refreshCnt_reg + 1'b1;
        if (state_reg == BMD_REFRESH) begin
          refreshPend_reg <= 1'b0;
        end
      end
    end
  end

  // One cycle at a time keeps the strobes simple: a RAM cycle walks IDLE,
  // WAIT and DONE, which gives the single wait state, and every other
  // target walks IDLE and DONE. Refresh starts only from IDLE, so it can
  // push a request back but never cut a RAM cycle in half. The cost is up
  // to two cycles of extra latency for a request that meets the timer.
  // Parity is absent by design: no parity lines exist on this path.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= BMD_IDLE;
      memReady    <= 1'b0;
      memRdata    <= 16'h0000;
      memTarget   <= BMD_TGT_NONE;
      ramSel      <= 1'b0;
      cardBankSel <= 1'b0;
      romSel      <= 1'b0;
      romAddr     <= 18'h00000;
      channelSel  <= 1'b0;
      refreshReq  <= 1'b0;
    end else begin
      memReady <= 1'b0;
      unique case (state_reg)
        BMD_IDLE: begin
          ramSel      <= 1'b0;
          cardBankSel <= 1'b0;
          romSel      <= 1'b0;
          channelSel  <= 1'b0;
          if (refreshPend_reg) begin
            state_reg  <= BMD_REFRESH;
            refreshReq <= 1'b1;
          end else if (memReq) begin
            memTarget <= target;
            if (target == BMD_TGT_RAM) begin
              ramSel      <= ~toCard;
              cardBankSel <= toCard;
              state_reg   <= BMD_WAIT;
            end else begin
              romSel     <= (target == BMD_TGT_ROM);
              channelSel <= (target != BMD_TGT_ROM);
              // The alias lands in the top 128KB of the ROM.
              romAddr    <= (memAddr >= ROM_BASE) ? memAddr[18:1]
                            : {2'b11, memAddr[16:1]};
              state_reg  <= BMD_DONE;
            end
          end
        end
        BMD_WAIT: begin
          state_reg <= BMD_DONE;
        end
        BMD_DONE: begin
          memReady  <= 1'b1;
          memRdata  <= romSel ? romData : 16'h0000;
          state_reg <= BMD_IDLE;
        end
        BMD_REFRESH: begin
          refreshReq <= 1'b0;
          state_reg  <= BMD_IDLE;
        end
      endcase
    end
  end

endmodule

// file: bmd_board_memory_sva.sv
// Checker for the board memory decoder, watching only the top module's ports.
// Assumes the bench holds memReq and memAddr steady until memReady is seen.
`timescale 1ns/1ps
module bmd_board_memory_sva
  import bmd_pkg::*;
(
  input wire logic                 clk,         // System clock.
  input wire logic                 arst_n,      // Reset, active low.
  input wire logic [23:0]          memAddr,     // Address of the cycle.
  input wire logic                 ioRead,      // I/O read strobe.
  input wire logic [15:0]          romData,     // ROM word.
  input wire logic                 memReady,    // Cycle complete.
  input wire logic [15:0]          memRdata,    // Read word.
  input bmd_pkg::bmd_target_t      memTarget,   // Decoded target.
  input wire logic                 ramSel,      // Soldered RAM strobe.
  input wire logic                 cardBankSel, // Card bank strobe.
  input wire logic                 romSel,      // ROM strobe.
  input wire logic [17:0]          romAddr,     // ROM word address.
  input wire logic                 channelSel,  // Channel strobe.
  input wire logic                 refreshReq,  // Refresh pulse.
  input wire logic [7:0]           ioRdata,     // I/O read data.
  input wire logic                 ioRvalid     // I/O read valid.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Counts edges since the last refresh; a small slack covers a refresh held off by up to two cycles.
  logic [10:0] gapCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) gapCnt <= 11'h000;
    else if (refreshReq) gapCnt <= 11'h001;
    else gapCnt <= gapCnt + 11'h001;
  end
  a_rom_window: assert property (memReady && memAddr >= ROM_BASE |-> memTarget == BMD_TGT_ROM && romSel)
    else $error("ROM window not decoded as ROM");
  a_rom_alias: assert property (memReady && memAddr inside {[ROM_ALIAS_BASE:ROM_ALIAS_TOP]}
    |-> romSel && romAddr == {2'b11, memAddr[16:1]}) else $error("ROM alias address wrong");
  a_rom_word: assert property (memReady && romSel |-> memRdata == $past(romData))
    else $error("ROM word not returned whole");
  a_video_adapter: assert property (memReady && memAddr inside {[VIDEO_BASE:ADAPTER_TOP]}
    |-> channelSel && !ramSel && !cardBankSel) else $error("Video or adapter window hit RAM");
  a_channel_pass: assert property (memReady && memAddr inside {[CHANNEL_BASE:CHANNEL_TOP]}
    |-> memTarget == BMD_TGT_CHANNEL && !ramSel && !cardBankSel) else $error("Channel window hit board");
  a_ram_wait: assert property ($rose(ramSel || cardBankSel) |-> !memReady ##1 !memReady ##1 memReady)
    else $error("RAM cycle not one wait state");
  a_refresh_idle: assert property (refreshReq |-> !ramSel && !cardBankSel)
    else $error("Refresh during RAM cycle");
  a_refresh_gap: assert property (refreshReq |-> gapCnt >= 11'h5D7 && gapCnt <= 11'h5E1)
    else $error("Refresh spacing wrong");
  a_refresh_due: assert property (gapCnt <= 11'h5E1) else $error("Refresh missing");
  a_io_read: assert property (ioRead |=> ioRvalid && ioRdata[7:5] == 3'b000)
    else $error("Port read reply wrong");
  c_ram: cover property (memReady && ramSel);
  c_card: cover property (memReady && cardBankSel);
  c_rom: cover property (memReady && romSel);
  c_refresh: cover property (refreshReq);
endmodule
bind bmd_board_memory bmd_board_memory_sva sva_i (.clk, .arst_n, .memAddr, .ioRead, .romData, .memReady,
  .memRdata, .memTarget, .ramSel, .cardBankSel, .romSel, .romAddr, .channelSel, .refreshReq, .ioRdata, .ioRvalid);

// file: bmd_rom_model.sv
// Model of the paired byte-wide ROM modules behind the decoder.
// Assumes romSel stays up for the whole ROM cycle.
`timescale 1ns/1ps
module bmd_rom_model (
  input  wire logic        clk,     // System clock.
  input  wire logic        romSel,  // ROM strobe.
  input  wire logic [17:0] romAddr, // ROM word address.
  output logic [15:0]      romData  // ROM word.
);
  // Unselected, the bus shows a pattern that flips every cycle so stale data cannot pass.
  logic [15:0] noise;
  always_ff @(posedge clk) noise <= (noise === 16'hA5A5) ? 16'h5A5A : 16'hA5A5;
  assign romData = romSel ? (romAddr[17:2] ^ 16'h5A3C) : noise;
endmodule

// file: test_board_memory_decode_control.sv
// Testbench for the board memory decoder: decode table, bank port, refresh.
// Assumes the ROM model above answers on romData.
`timescale 1ns/1ps
module test_board_memory_decode_control;
  import bmd_pkg::*;
  logic clk = 0, arst_n = 0, memReq = 0, memWrite = 0, ioWrite = 0, ioRead = 0, setupMode = 0, ramOptionIn = 0;
  logic [23:0] memAddr = 0;
  logic [15:0] ioAddr = 0, romData, memRdata;
  logic [7:0] ioWdata = 0, ioRdata;
  logic memReady, ramSel, cardBankSel, romSel, channelSel, refreshReq, ioRvalid;
  logic [17:0] romAddr;
  bmd_target_t memTarget;
  int err_count = 0, num_checks = 0, gap;
  bmd_board_memory bmd_board_memory_i (.clk, .arst_n, .memReq, .memWrite, .memAddr, .ioWrite, .ioRead, .ioAddr,
    .ioWdata, .setupMode, .ramOptionIn, .romData, .memReady, .memRdata, .memTarget, .ramSel, .cardBankSel,
    .romSel, .romAddr, .channelSel, .refreshReq, .ioRdata, .ioRvalid);
  bmd_rom_model bmd_rom_model_i (.clk, .romSel, .romAddr, .romData);
  initial begin
    forever #5 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  // Selects are {ram, card, rom, channel}; the request drops as soon as memReady shows.
  task acc(input logic [23:0] a, input bmd_target_t t, input logic [3:0] s);
    logic [17:0] ra;
    int n;
    ra = (a >= ROM_BASE) ? a[18:1] : {2'b11, a[16:1]};
    @(posedge clk); #1;
    memAddr = a;
    memReq = 1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (memReady !== 1'b1 && n < 20);
    check({memTarget, ramSel, cardBankSel, romSel, channelSel}, {t, s});
    check(memRdata, t == BMD_TGT_ROM ? ra[17:2] ^ 16'h5A3C : 16'h0000);
    memReq = 0;
  endtask
  task iow(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    ioAddr = a; ioWdata = d; ioWrite = 1;
    @(posedge clk); #1;
    ioWrite = 0;
  endtask
  task ior(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk); #1;
    ioAddr = a; ioRead = 1;
    @(posedge clk); #1;
    ioRead = 0;
    check({ioRvalid, ioRdata}, {1'b1, e});
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1;
    acc(24'h000000, BMD_TGT_RAM, 4'b1000);
    acc(24'h09FFFE, BMD_TGT_RAM, 4'b1000);
    acc(24'h0A0000, BMD_TGT_VIDEO, 4'b0001);
    acc(24'h0DFFFF, BMD_TGT_ADAPTER, 4'b0001);
    acc(24'h0E0002, BMD_TGT_ROM, 4'b0010);
    acc(24'hF80000, BMD_TGT_ROM, 4'b0010);
    acc(24'hFFFFFE, BMD_TGT_ROM, 4'b0010);
    acc(24'h100000, BMD_TGT_CHANNEL, 4'b0001);
    acc(24'hF7FFFF, BMD_TGT_CHANNEL, 4'b0001);
    $display("test decode done");
    ramOptionIn = 1;
    repeat (8) @(posedge clk);
    acc(24'h07FFFE, BMD_TGT_RAM, 4'b1000);
    acc(24'h080000, BMD_TGT_RAM, 4'b0100);
    acc(24'h100000, BMD_TGT_RAM, 4'b0100);
    acc(24'h15FFFE, BMD_TGT_RAM, 4'b0100);
    acc(24'h160000, BMD_TGT_CHANNEL, 4'b0001);
    $display("test option done");
    ior(16'h0104, 8'h1F);
    iow(16'h0104, 8'h00);
    ior(16'h0104, 8'h1F);
    setupMode = 1;
    iow(16'h0104, 8'hFE);
    ior(16'h0104, 8'h1E);
    iow(16'h0105, 8'h00);
    ior(16'h0104, 8'h1E);
    ior(16'h0105, 8'h00);
    acc(24'h000000, BMD_TGT_CHANNEL, 4'b0001);
    acc(24'h020000, BMD_TGT_RAM, 4'b1000);
    iow(16'h0104, 8'hEF);
    acc(24'h080000, BMD_TGT_CHANNEL, 4'b0001);
    iow(16'h0104, 8'hFF);
    setupMode = 0;
    ior(16'h0104, 8'h1F);
    $display("test bank port done");
    // Back-to-back RAM traffic of about 1400 cycles, a little under one refresh period, so a refresh may fall among it.
    for (int i = 0; i < 350; i++) acc(24'h020000, BMD_TGT_RAM, 4'b1000);
    repeat (4) @(posedge clk);
    // Traffic may have held the last refresh back; idle spacing is the bare timer period.
    gap = 0;
    do begin @(posedge clk); #1; gap++; end while (refreshReq !== 1'b1 && gap < 2000);
    gap = 0;
    do begin @(posedge clk); #1; gap++; end while (refreshReq !== 1'b1 && gap < 2000);
    check(gap, REFRESH_CYCLES);
    @(posedge clk); #1;
    check(refreshReq, 1'b0);
    $display("test refresh done");
    give_verdict;
  end
endmodule
